// file: muc_conv_pulse.sv
// Meter-unit to display-unit conversion and two meter pulse outputs
// Operation
// - Every result reads as 64 bits, only low 48 carry data.
// - Host may read shorter lengths, e.g. low word only, losing bits 47:32.
// - Display voltage/current is 32-bit RMS times 16-bit scale.
// - Scales only convert units; calibration gains live elsewhere.
// - Power is cycle energy times power scale over sample count.
// - Power factor is real over apparent, scaled by 2^14.
// - Line frequency in millihertz from mean of three counts.
// - Phasor angle reported in hundredths of a degree.
// - Net energy is forward minus reverse, times energy scale.
// - Net energy counts only since last overflow; host corrects.
// - Two independent pulse outputs with own settings.
// - One polarity bit picks active-high or active-low pulses.
// - Triggered pulse stays active for width; retrigger extends.
// - Width counts frame periods, reset value 156 frames.
// - Each generator sums one quantity over enabled phases.
// - Quantity choice covers energies, RMS values, quadrants.
// - Three phase include bits per generator, any subset.
// - Per DSP cycle add quantity; above threshold pulse, subtract.
// - All pulses suppressed while start delay is nonzero.
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`include "muc_regs.svh"
module muc_conv_pulse #(
   parameter int LINE_CYCLES = 1
) (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic [11:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   output logic [31:0] reg_rdata_o,
   input muc_pkg::muc_phase_t [2:0] phase_i,
   input wire logic dsp_cycle_i,
   input wire logic frame_tick_i,
   output logic pulse_one_o,
   output logic pulse_two_o
);
   import muc_pkg::*;

   localparam logic [63:0] FREQ_NUM = 64'(LINE_CYCLES) * `MUC_MHZ_PER_HZ
      * `MUC_US_PER_S / `MUC_FRAME_US;

   logic [15:0] voltage_display_scale, next_voltage_display_scale;
   logic [15:0] current_display_scale, next_current_display_scale;
   logic [15:0] power_display_scale, next_power_display_scale;
   logic [15:0] energy_display_scale, next_energy_display_scale;
   logic pulse_polarity_select, next_pulse_polarity_select;
   logic [15:0] width [2];
   logic [15:0] next_width [2];
   muc_pulse_cfg_t cfg [2];
   muc_pulse_cfg_t next_cfg [2];
   logic [31:0] thr [2];
   logic [31:0] next_thr [2];
   logic [7:0] accumulation_start_delay, next_accumulation_start_delay;
   logic [47:0] res [`MUC_RES_COUNT];
   logic [47:0] next_res [`MUC_RES_COUNT];
   logic [31:0] rdata, next_rdata;
   logic [1:0] active;
   logic [1:0] pulse;
   logic signed [63:0] prod;
   logic [17:0] count_sum;
   logic [17:0] count_mean;
   logic [4:0] res_idx;
   logic suppress;

   // Signed quotient, zero when the divisor is zero
   function automatic logic [47:0] sdiv(input logic signed [63:0] n,
      input logic [31:0] d);
      logic signed [63:0] q;
      q = (d == 32'h0) ? 64'sh0 : n / $signed({32'h0, d});
      return q[47:0];
   endfunction

   // Signed value times an unsigned scale
   function automatic logic signed [63:0] mul_s(input logic signed [32:0] a,
      input logic [15:0] b);
      return 64'(a) * $signed({48'h0, b});
   endfunction

   assign suppress = (accumulation_start_delay != 8'h00);
   assign res_idx = reg_addr_i[7:3];

   // Register writes and start-delay countdown
   always_comb
   begin
      next_voltage_display_scale = voltage_display_scale;
      next_current_display_scale = current_display_scale;
      next_power_display_scale = power_display_scale;
      next_energy_display_scale = energy_display_scale;
      next_pulse_polarity_select = pulse_polarity_select;
      next_width = width;
      next_cfg = cfg;
      next_thr = thr;
      next_accumulation_start_delay = accumulation_start_delay;
      if (dsp_cycle_i && suppress)
         next_accumulation_start_delay = accumulation_start_delay - 8'h01;
      if (reg_write_i)
      begin
         case (reg_addr_i)
            `MUC_OFS_VSCALE: next_voltage_display_scale = reg_wdata_i[15:0];
            `MUC_OFS_ISCALE: next_current_display_scale = reg_wdata_i[15:0];
            `MUC_OFS_PSCALE: next_power_display_scale = reg_wdata_i[15:0];
            `MUC_OFS_ESCALE: next_energy_display_scale = reg_wdata_i[15:0];
            `MUC_OFS_OPCFG1:
               next_pulse_polarity_select = reg_wdata_i[`MUC_POL_BIT];
            `MUC_OFS_P1WIDTH: next_width[0] = reg_wdata_i[15:0];
            `MUC_OFS_P2WIDTH: next_width[1] = reg_wdata_i[15:0];
            `MUC_OFS_P1CFG:
               next_cfg[0] = muc_pulse_cfg_t'(reg_wdata_i[`MUC_CFG_W-1:0]);
            `MUC_OFS_P2CFG:
               next_cfg[1] = muc_pulse_cfg_t'(reg_wdata_i[`MUC_CFG_W-1:0]);
            `MUC_OFS_P1THR: next_thr[0] = reg_wdata_i;
            `MUC_OFS_P2THR: next_thr[1] = reg_wdata_i;
            `MUC_OFS_DELAY: next_accumulation_start_delay = reg_wdata_i[7:0];
            default: ;
         endcase
      end
   end

   // Conversions, refreshed at the end of each DSP cycle
   always_comb
   begin
      prod = '0;
      count_sum = '0;
      count_mean = '0;
      for (int k = 0; k < `MUC_RES_COUNT; k++)
         next_res[k] = res[k];
      if (dsp_cycle_i)
      begin
         for (int p = 0; p < 3; p++)
         begin
            next_res[`MUC_RES_VOLT + p] = 48'(phase_i[p].rms_voltage_raw)
               * 48'(voltage_display_scale);
            next_res[`MUC_RES_CURR + p] = 48'(phase_i[p].rms_current_raw)
               * 48'(current_display_scale);
            next_res[`MUC_RES_PACT + p] = sdiv(mul_s(
               33'(phase_i[p].act_energy), power_display_scale),
               {16'h0, phase_i[p].samples_per_dsp_cycle});
            next_res[`MUC_RES_PREA + p] = sdiv(mul_s(
               33'(phase_i[p].react_energy), power_display_scale),
               {16'h0, phase_i[p].samples_per_dsp_cycle});
            next_res[`MUC_RES_PAPP + p] = sdiv(mul_s(
               33'(phase_i[p].app_energy), power_display_scale),
               {16'h0, phase_i[p].samples_per_dsp_cycle});
            next_res[`MUC_RES_PF + p] = sdiv(
               64'(phase_i[p].act_energy) <<< `MUC_PF_SHIFT,
               phase_i[p].app_energy);
            prod = mul_s($signed({1'b0, phase_i[p].real_energy_forward_acc})
               - $signed({1'b0, phase_i[p].real_energy_reverse_acc}),
               energy_display_scale);
            next_res[`MUC_RES_NET + p] = prod[47:0];
         end
         count_sum = 18'(phase_i[0].samples_per_dsp_cycle)
            + 18'(phase_i[1].samples_per_dsp_cycle)
            + 18'(phase_i[2].samples_per_dsp_cycle);
         count_mean = count_sum / 18'h3;
         next_res[`MUC_RES_FREQ] = sdiv(FREQ_NUM, 32'(count_mean));
         for (int p = 1; p < 3; p++)
            next_res[`MUC_RES_ANG + p - 1] = sdiv(
               64'(phase_i[p].crossing_lag) * `MUC_CDEG_TURN,
               {16'h0, phase_i[0].samples_per_dsp_cycle});
      end
   end

   // Read data for the cycle after the strobe
   always_comb
   begin
      next_rdata = 32'h0;
      if (reg_read_i)
      begin
         if (reg_addr_i[11:8] == `MUC_RES_PAGE)
         begin
            if (res_idx < `MUC_RES_COUNT && !reg_addr_i[0])
               next_rdata = reg_addr_i[2] ? {16'h0, res[res_idx][47:32]}
                  : res[res_idx][31:0];
         end
         else
         begin
            case (reg_addr_i)
               `MUC_OFS_VSCALE: next_rdata = {16'h0, voltage_display_scale};
               `MUC_OFS_ISCALE: next_rdata = {16'h0, current_display_scale};
               `MUC_OFS_PSCALE: next_rdata = {16'h0, power_display_scale};
               `MUC_OFS_ESCALE: next_rdata = {16'h0, energy_display_scale};
               `MUC_OFS_OPCFG1: next_rdata = {31'h0, pulse_polarity_select};
               `MUC_OFS_P1WIDTH: next_rdata = {16'h0, width[0]};
               `MUC_OFS_P2WIDTH: next_rdata = {16'h0, width[1]};
               `MUC_OFS_P1CFG: next_rdata = {25'h0, cfg[0]};
               `MUC_OFS_P2CFG: next_rdata = {25'h0, cfg[1]};
               `MUC_OFS_P1THR: next_rdata = thr[0];
               `MUC_OFS_P2THR: next_rdata = thr[1];
               `MUC_OFS_DELAY: next_rdata = {24'h0, accumulation_start_delay};
               `MUC_OFS_STATUS: next_rdata = {29'h0, suppress, active};
               default: next_rdata = 32'h0;
            endcase
         end
      end
   end

   // Register state
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         voltage_display_scale <= `MUC_RST_SCALE;
         current_display_scale <= `MUC_RST_SCALE;
         power_display_scale <= `MUC_RST_SCALE;
         energy_display_scale <= `MUC_RST_SCALE;
         pulse_polarity_select <= `MUC_RST_POL;
         width[0] <= `MUC_RST_WIDTH;
         width[1] <= `MUC_RST_WIDTH;
         cfg[0] <= muc_pulse_cfg_t'(`MUC_RST_CFG);
         cfg[1] <= muc_pulse_cfg_t'(`MUC_RST_CFG);
         thr[0] <= `MUC_RST_THR;
         thr[1] <= `MUC_RST_THR;
         accumulation_start_delay <= `MUC_RST_DELAY;
         for (int k = 0; k < `MUC_RES_COUNT; k++)
            res[k] <= 48'h0;
         rdata <= 32'h0;
      end
      else
      begin
         voltage_display_scale <= next_voltage_display_scale;
         current_display_scale <= next_current_display_scale;
         power_display_scale <= next_power_display_scale;
         energy_display_scale <= next_energy_display_scale;
         pulse_polarity_select <= next_pulse_polarity_select;
         width <= next_width;
         cfg <= next_cfg;
         thr <= next_thr;
         accumulation_start_delay <= next_accumulation_start_delay;
         res <= next_res;
         rdata <= next_rdata;
      end
   end

   assign reg_rdata_o = rdata;

   for (genvar g = 0; g < 2; g++)
   begin : gen_pulse
      muc_pulse_gen u_pulse (
         .core_clk_i(core_clk_i),
         .resetn_i(resetn_i),
         .phase_i(phase_i),
         .cfg_i(cfg[g]),
         .threshold_i(thr[g]),
         .width_i(width[g]),
         .polarity_i(pulse_polarity_select),
         .suppress_i(suppress),
         .dsp_cycle_i(dsp_cycle_i),
         .frame_tick_i(frame_tick_i),
         .pulse_o(pulse[g]),
         .active_o(active[g])
      );
   end
   assign pulse_one_o = pulse[0];
   assign pulse_two_o = pulse[1];

   property p_volt;
      @(posedge core_clk_i) disable iff (!resetn_i)
      dsp_cycle_i |=> res[`MUC_RES_VOLT] ==
         48'($past(phase_i[0].rms_voltage_raw)) * 48'($past(
         voltage_display_scale));
   endproperty
   a_volt: assert property (p_volt)
      else $error("voltage result not RMS times scale");

   property p_pf_unity;
      @(posedge core_clk_i) disable iff (!resetn_i)
      (dsp_cycle_i && phase_i[1].act_energy == phase_i[1].app_energy
         && phase_i[1].act_energy > 0) |=> res[`MUC_RES_PF + 1] == 48'h4000;
   endproperty
   a_pf_unity: assert property (p_pf_unity)
      else $error("unity power factor not 0x4000");

   property p_hiword;
      @(posedge core_clk_i) disable iff (!resetn_i)
      (reg_read_i && reg_addr_i[11:8] == `MUC_RES_PAGE && reg_addr_i[2])
         |=> reg_rdata_o[31:16] == 16'h0000 ##1 reg_rdata_o == 32'h0
         || $past(reg_read_i);
   endproperty
   a_hiword: assert property (p_hiword)
      else $error("result upper bits not zero");

   property p_delay;
      @(posedge core_clk_i) disable iff (!resetn_i)
      (dsp_cycle_i && suppress && !(reg_write_i
         && reg_addr_i == `MUC_OFS_DELAY)) |=> accumulation_start_delay ==
         $past(accumulation_start_delay) - 8'h01;
   endproperty
   a_delay: assert property (p_delay)
      else $error("start delay did not count down");
endmodule

// file: muc_regs.svh
// Register offsets, reset values, result indices and timing figures
`ifndef MUC_REGS_SVH
`define MUC_REGS_SVH
`define MUC_OFS_VSCALE 12'h000
`define MUC_OFS_ISCALE 12'h004
`define MUC_OFS_PSCALE 12'h008
`define MUC_OFS_ESCALE 12'h00c
`define MUC_OFS_OPCFG1 12'h010
`define MUC_OFS_P1WIDTH 12'h014
`define MUC_OFS_P2WIDTH 12'h018
`define MUC_OFS_P1CFG 12'h01c
`define MUC_OFS_P2CFG 12'h020
`define MUC_OFS_P1THR 12'h024
`define MUC_OFS_P2THR 12'h028
`define MUC_OFS_DELAY 12'h02c
`define MUC_OFS_STATUS 12'h030
// Results sit at 0x100 + 8 * index, low word first
`define MUC_RES_PAGE 4'h1
`define MUC_POL_BIT 0
`define MUC_CFG_W 7
`define MUC_RST_SCALE 16'h0001
`define MUC_RST_POL 1'b1
`define MUC_RST_WIDTH 16'h009c
`define MUC_RST_CFG 7'h00
`define MUC_RST_THR 32'hffffffff
`define MUC_RST_DELAY 8'h05
`define MUC_RES_VOLT 0
`define MUC_RES_CURR 3
`define MUC_RES_PACT 6
`define MUC_RES_PREA 9
`define MUC_RES_PAPP 12
`define MUC_RES_PF 15
`define MUC_RES_FREQ 18
`define MUC_RES_ANG 19
`define MUC_RES_NET 21
`define MUC_RES_COUNT 24
`define MUC_FRAME_US 64'h140
`define MUC_US_PER_S 64'hf4240
`define MUC_MHZ_PER_HZ 64'h3e8
`define MUC_PF_SHIFT 14
`define MUC_CDEG_TURN 64'h8ca0
`endif

// file: muc_pkg.sv
// Types shared by the conversion and pulse logic
package muc_pkg;
   // Per-phase results handed over by the measurement core
   typedef struct packed {
      logic [31:0] rms_voltage_raw;
      logic [31:0] rms_current_raw;
      logic signed [31:0] act_energy;
      logic signed [31:0] react_energy;
      logic signed [31:0] app_energy;
      logic [31:0] real_energy_forward_acc;
      logic [31:0] real_energy_reverse_acc;
      logic [15:0] samples_per_dsp_cycle;
      logic [15:0] crossing_lag;
   } muc_phase_t;
   // Pulse quantity choices
   typedef enum logic [3:0] {
      muc_q_act_arith = 4'h0,
      muc_q_act_abs = 4'h1,
      muc_q_rms_volt = 4'h2,
      muc_q_rms_curr = 4'h3,
      muc_q_real_pos = 4'h4,
      muc_q_real_neg = 4'h5,
      muc_q_react_q1 = 4'h6,
      muc_q_react_q2 = 4'h7,
      muc_q_react_q3 = 4'h8,
      muc_q_react_q4 = 4'h9,
      muc_q_apparent = 4'ha
   } muc_qsel_t;
   typedef struct packed {
      logic [2:0] phases;
      muc_qsel_t qsel;
   } muc_pulse_cfg_t;
endpackage

// file: muc_pulse_gen.sv
// One meter pulse generator: accumulator, threshold and width counter
module muc_pulse_gen #(
   parameter int ACC_W = 40
) (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input muc_pkg::muc_phase_t [2:0] phase_i,
   input muc_pkg::muc_pulse_cfg_t cfg_i,
   input wire logic [31:0] threshold_i,
   input wire logic [15:0] width_i,
   input wire logic polarity_i,
   input wire logic suppress_i,
   input wire logic dsp_cycle_i,
   input wire logic frame_tick_i,
   output logic pulse_o,
   output logic active_o
);
   import muc_pkg::*;

   logic signed [ACC_W-1:0] acc, next_acc, sum, total, thr_ext;
   logic [15:0] count, next_count;
   logic pulse, next_pulse, trigger;

   function automatic logic signed [ACC_W-1:0] pos(
      input logic signed [31:0] v);
      return v[31] ? '0 : ACC_W'(v);
   endfunction

   function automatic logic signed [ACC_W-1:0] neg(
      input logic signed [31:0] v);
      return v[31] ? -ACC_W'(v) : '0;
   endfunction

   // Per-phase contribution of the chosen quantity
   function automatic logic signed [ACC_W-1:0] quantity(
      input muc_phase_t ph, input muc_qsel_t q);
      logic a_pos;
      a_pos = !ph.act_energy[31];
      case (q)
         muc_q_act_arith: return ACC_W'(ph.act_energy);
         muc_q_act_abs: return pos(ph.act_energy) + neg(ph.act_energy);
         muc_q_rms_volt: return ACC_W'(ph.rms_voltage_raw);
         muc_q_rms_curr: return ACC_W'(ph.rms_current_raw);
         muc_q_real_pos: return pos(ph.act_energy);
         muc_q_real_neg: return neg(ph.act_energy);
         muc_q_react_q1: return a_pos ? pos(ph.react_energy) : '0;
         muc_q_react_q2: return a_pos ? '0 : pos(ph.react_energy);
         muc_q_react_q3: return a_pos ? '0 : neg(ph.react_energy);
         muc_q_react_q4: return a_pos ? neg(ph.react_energy) : '0;
         muc_q_apparent: return pos(ph.app_energy);
         default: return '0;
      endcase
   endfunction

   // Accumulate, compare, reload and count down
   always_comb
   begin
      sum = '0;
      for (int p = 0; p < 3; p++)
      begin
         if (cfg_i.phases[p])
            sum = sum + quantity(phase_i[p], cfg_i.qsel);
      end
      total = acc + sum;
      thr_ext = ACC_W'($signed({1'b0, threshold_i}));
      trigger = dsp_cycle_i && !suppress_i && (total > thr_ext);
      next_acc = acc;
      if (dsp_cycle_i && !suppress_i)
         next_acc = trigger ? total - thr_ext : total;
      next_count = count;
      if (trigger)
         next_count = width_i;
      else if (frame_tick_i && count != 16'h0000)
         next_count = count - 16'h0001;
      next_pulse = (next_count != 16'h0000 && !suppress_i) ?
         polarity_i : !polarity_i;
   end

   // State registers
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         acc <= '0;
         count <= 16'h0000;
         pulse <= 1'b0;
      end
      else
      begin
         acc <= next_acc;
         count <= next_count;
         pulse <= next_pulse;
      end
   end

   assign pulse_o = pulse;
   assign active_o = (count != 16'h0000);

   property p_idle_level;
      @(posedge core_clk_i) disable iff (!resetn_i)
      (count == 16'h0000) |-> (pulse_o == !$past(polarity_i));
   endproperty
   a_idle_level: assert property (p_idle_level)
      else $error("pulse not inactive with zero count");

   property p_reload;
      @(posedge core_clk_i) disable iff (!resetn_i)
      trigger |=> (count == $past(width_i)) && (pulse_o == $past(polarity_i)
         || $past(width_i) == 16'h0000);
   endproperty
   a_reload: assert property (p_reload)
      else $error("trigger did not load width");

   property p_decrement;
      @(posedge core_clk_i) disable iff (!resetn_i)
      (frame_tick_i && !trigger && count != 16'h0000)
         |=> count == $past(count) - 16'h0001;
   endproperty
   a_decrement: assert property (p_decrement)
      else $error("width count did not step per frame");

   property p_suppress;
      @(posedge core_clk_i) disable iff (!resetn_i)
      suppress_i |=> pulse_o == !$past(polarity_i);
   endproperty
   a_suppress: assert property (p_suppress)
      else $error("pulse active during start delay");

   property p_subtract;
      @(posedge core_clk_i) disable iff (!resetn_i)
      trigger |=> acc == $past(total) - $past(thr_ext);
   endproperty
   a_subtract: assert property (p_subtract)
      else $error("threshold not subtracted");

   property p_frozen;
      @(posedge core_clk_i) disable iff (!resetn_i)
      suppress_i |=> acc == $past(acc);
   endproperty
   a_frozen: assert property (p_frozen)
      else $error("accumulator moved during start delay");
endmodule

// file: muc_meter_env.sv
// Far-side model: free-running frame ticks and two meter pulse counters
module muc_meter_env #(
   parameter int FRAME = 8
) (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic active_high_i,
   input wire logic pulse_one_i,
   input wire logic pulse_two_i,
   output logic frame_tick_o,
   output int ticks_one_o,
   output int ticks_two_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int div;
   // Frame ticks counted while each pulse sits at its active level
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         div <= 0;
         frame_tick_o <= 1'b0;
         ticks_one_o <= 0;
         ticks_two_o <= 0;
      end
      else
      begin
         div <= (div == FRAME - 1) ? 0 : div + 1;
         frame_tick_o <= (div == FRAME - 1);
         if (frame_tick_o && pulse_one_i == active_high_i)
            ticks_one_o <= ticks_one_o + 1;
         if (frame_tick_o && pulse_two_i == active_high_i)
            ticks_two_o <= ticks_two_o + 1;
      end
   end
endmodule

// file: test_muc_conv_pulse.sv
// Self-checking bench for the conversion and meter pulse block
`include "muc_regs.svh"
module test_muc_conv_pulse;
   timeunit 1ns;
   timeprecision 1ns;
   import muc_pkg::*;
   logic core_clk_i = 0, resetn_i = 0, wr = 0, rd = 0, dsp = 0, pol = 1;
   logic [11:0] addr = '0;
   logic [31:0] wdata = '0, rdata, d;
   logic p1, p2, tick;
   muc_phase_t [2:0] ph = '0;
   int errors = 0, checks_done = 0, t1, t2, s1, s2;
   always #25 core_clk_i = ~core_clk_i;
   muc_conv_pulse muc_conv_pulse_i (.core_clk_i(core_clk_i),
      .resetn_i(resetn_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_write_i(wr), .reg_read_i(rd), .reg_rdata_o(rdata),
      .phase_i(ph), .dsp_cycle_i(dsp), .frame_tick_i(tick),
      .pulse_one_o(p1), .pulse_two_o(p2));
   muc_meter_env muc_meter_env_i (.core_clk_i(core_clk_i),
      .resetn_i(resetn_i), .active_high_i(pol), .pulse_one_i(p1),
      .pulse_two_i(p2), .frame_tick_o(tick), .ticks_one_o(t1),
      .ticks_two_o(t2));
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [11:0] a, input logic [31:0] v);
      @(posedge core_clk_i);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge core_clk_i);
      wr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [11:0] a, output logic [31:0] v);
      @(posedge core_clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk_i);
      rd <= 1'b0;
      @(negedge core_clk_i);
      v = rdata;
   endtask
   task automatic chk_res(input int n, input logic [47:0] exp);
      logic [31:0] lo, hi;
      rd_reg(12'h100 + 12'(8 * n), lo);
      rd_reg(12'h104 + 12'(8 * n), hi);
      chk({hi, lo}, {16'h0000, exp});
   endtask
   // End of DSP cycle one clock after a frame tick
   task automatic dsp_pulse();
      @(posedge core_clk_i iff tick);
      dsp <= 1'b1;
      @(posedge core_clk_i);
      dsp <= 1'b0;
   endtask
   task automatic t_reset();
      rd_reg(`MUC_OFS_P1WIDTH, d);
      chk(d, 64'h9c);
      rd_reg(`MUC_OFS_P2WIDTH, d);
      chk(d, 64'h9c);
      rd_reg(`MUC_OFS_OPCFG1, d);
      chk(d[0], 64'h1);
      rd_reg(12'h3f0, d);
      chk(d, 64'h0);
      chk({p1, p2}, 64'h0);
      $display("t_reset done");
   endtask
   task automatic t_conv();
      @(posedge core_clk_i);
      for (int i = 0; i < 3; i++)
      begin
         ph[i].rms_voltage_raw <= 32'h89abcdef;
         ph[i].rms_current_raw <= 32'h00010000;
         ph[i].act_energy <= 32'sd1000;
         ph[i].app_energy <= 32'sd1000;
         ph[i].real_energy_forward_acc <= 32'd500;
         ph[i].real_energy_reverse_acc <= 32'd200;
         ph[i].samples_per_dsp_cycle <= 16'd500;
         ph[i].crossing_lag <= 16'd125;
      end
      wr_reg(`MUC_OFS_VSCALE, 32'hfedc);
      wr_reg(`MUC_OFS_ISCALE, 32'h0003);
      wr_reg(`MUC_OFS_PSCALE, 32'h0005);
      wr_reg(`MUC_OFS_ESCALE, 32'h0007);
      dsp_pulse();
      chk_res(0, 48'h89abcdef * 48'hfedc);
      chk_res(4, 48'h30000);
      chk_res(6, 48'd10);
      chk_res(15, 48'h4000);
      chk_res(18, 48'd6250);
      chk_res(19, 48'd9000);
      chk_res(23, 48'd2100);
      rd_reg(12'h178, d);
      chk(d, 64'h4000);
      $display("t_conv done");
   endtask
   task automatic t_pulse();
      wr_reg(`MUC_OFS_P1WIDTH, 32'h3);
      wr_reg(`MUC_OFS_P2WIDTH, 32'h2);
      wr_reg(`MUC_OFS_P1CFG, 32'h12);
      wr_reg(`MUC_OFS_P2CFG, 32'h63);
      wr_reg(`MUC_OFS_P1THR, 32'h89abcdee);
      wr_reg(`MUC_OFS_P2THR, 32'h0001ffff);
      wr_reg(`MUC_OFS_DELAY, 32'h0);
      s1 = t1;
      s2 = t2;
      dsp_pulse();
      @(posedge core_clk_i iff tick);
      dsp_pulse();
      repeat (60) @(negedge core_clk_i);
      chk(t1 - s1, 64'd5);
      chk(t2 - s2, 64'd4);
      chk({p1, p2}, 64'h0);
      $display("t_pulse done");
   endtask
   task automatic t_supp();
      wr_reg(`MUC_OFS_DELAY, 32'h3);
      s1 = t1;
      s2 = t2;
      dsp_pulse();
      repeat (30) @(negedge core_clk_i);
      chk(t1 - s1, 64'd0);
      chk(t2 - s2, 64'd0);
      rd_reg(`MUC_OFS_DELAY, d);
      chk(d, 64'h2);
      $display("t_supp done");
   endtask
   task automatic t_pol();
      wr_reg(`MUC_OFS_OPCFG1, 32'h0);
      pol <= 1'b0;
      repeat (2) @(negedge core_clk_i);
      chk({p1, p2}, 64'h3);
      wr_reg(`MUC_OFS_DELAY, 32'h0);
      s1 = t1;
      s2 = t2;
      dsp_pulse();
      repeat (40) @(negedge core_clk_i);
      chk(t1 - s1, 64'd3);
      chk(t2 - s2, 64'd2);
      $display("t_pol done");
   endtask
   // Signed and quadrant quantities: first pass must not fire, second must
   task automatic t_qsel();
      @(posedge core_clk_i);
      ph[0].act_energy <= -32'sd1000;
      ph[0].react_energy <= -32'sd500;
      wr_reg(`MUC_OFS_P1THR, 32'ha);
      wr_reg(`MUC_OFS_P2THR, 32'ha);
      wr_reg(`MUC_OFS_P1CFG, 32'h10);
      wr_reg(`MUC_OFS_P2CFG, 32'h16);
      dsp_pulse();
      rd_reg(`MUC_OFS_STATUS, d);
      chk(d, 64'h0);
      wr_reg(`MUC_OFS_P1THR, 32'h0);
      wr_reg(`MUC_OFS_P2THR, 32'h1f3);
      wr_reg(`MUC_OFS_P1CFG, 32'h15);
      wr_reg(`MUC_OFS_P2CFG, 32'h18);
      dsp_pulse();
      rd_reg(`MUC_OFS_STATUS, d);
      chk(d, 64'h3);
      chk({p1, p2}, 64'h0);
      $display("t_qsel done");
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      repeat (3) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      t_reset();
      t_conv();
      t_pulse();
      t_supp();
      t_pol();
      t_qsel();
      close_out();
   end
   // Watchdog against a hang
   initial
   begin
      #1000000;
      errors++;
      $display("MISMATCH %0t watchdog expired", $time);
      close_out();
   end
endmodule
